// ==== wdt_cfg.svh ====
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ==========================================================================
// Register offsets
`define WDT_CTRL_OFS   12'h000
`define WDT_STS_OFS    12'h004
`define WDT_MSK_OFS    12'h008

// ==========================================================================
// Control field positions
`define WDT_B_RESTART  0
`define WDT_B_RSTEN    1
`define WDT_B_FLAG     3
`define WDT_B_SEL_LO   4
`define WDT_B_SEL_HI   5
`define WDT_B_IRQEN    6
`define WDT_B_POR      7

// ==========================================================================
// Status and mask field positions
`define WDT_B_EV_INTV  0
`define WDT_B_EV_RST   1

// ==========================================================================
// Reset values
`define WDT_SEL_RST    2'h0
`define WDT_EVT_RST    2'h0

// ==========================================================================
// Timing counts in system clocks
`define WDT_INTV0      22'h001000
`define WDT_INTV1      22'h008000
`define WDT_INTV2      22'h040000
`define WDT_INTV3      22'h200000
`define WDT_RST_LAST   9'h1ff

`endif

// ==== wdt_pkg.sv ====
`default_nettype none

package wdt_pkg;

  // ========================================================================
  // Watchdog phases
  typedef enum logic [1:0] {
    WDT_HALT,
    WDT_COUNT,
    WDT_RWAIT
  } wdt_phase_t;

  // ========================================================================
  // APB request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wdt_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdt_apb_rsp_t;

  // ========================================================================
  // Whole watchdog state
  typedef struct packed {
    wdt_phase_t  st;
    logic [21:0] cnt;
    logic [8:0]  rcnt;
    logic [1:0]  sel;
    logic        irq_en;
    logic        rst_en;
    logic        flag;
    logic        por;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        irq;
    logic        wdrst;
  } wdt_state_t;

endpackage

`default_nettype wire

// ==== wdt_sync2.sv ====
`default_nettype none

module wdt_sync2 (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Level
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_reg;
  logic sync_reg;

  // ========================================================================
  // Two stage synchroniser
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule

`default_nettype wire

// ==== wdt_apb_slv.sv ====
`default_nettype none

module wdt_apb_slv
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Bus side
  input  wire wdt_apb_req_t req_i,
  output wdt_apb_rsp_t      rsp_o,
  // Register side
  input  wire logic [31:0]  rd_data_i,
  input  wire logic         rd_hit_i,
  output logic              wr_o
);

  wdt_apb_rsp_t rsp_reg;
  wdt_apb_rsp_t rsp_next;
  logic         acc;

  // ========================================================================
  // One wait state, then answer
  assign acc  = req_i.psel & req_i.penable;
  assign wr_o = acc & rsp_reg.pready & req_i.pwrite & rd_hit_i;

  always_comb begin
    rsp_next        = rsp_reg;
    rsp_next.pready = 1'b0;
    if (acc && !rsp_reg.pready) begin
      rsp_next.pready  = 1'b1;
      rsp_next.pslverr = ~rd_hit_i;
      rsp_next.prdata  = (req_i.pwrite || !rd_hit_i) ? 32'h0 : rd_data_i;
    end else if (!acc) begin
      rsp_next.pslverr = 1'b0;
      rsp_next.prdata  = 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp_o = rsp_reg;

endmodule

`default_nettype wire

// ==== wdt_top.sv ====
`include "wdt_cfg.svh"
`default_nettype none

// How it works
// - Two-bit select picks one of four intervals
// - Reset fires interval plus 512 clocks later
// - Enabled flag raises an interrupt request
// - Disabled interrupt still counts and resets
// - Counter halts when both enables clear
// - Enabling from halt clears counts, restarts
// - Interrupt enable cleared by control write or power-on
// - Power-on or brownout sets power flag
// - Power flag kept through other resets
// - Restart bit clears count, reads zero
// - Interval end or software sets flag
// - New select restarts unless reset pending
// - Clearing reset enable cancels pending reset, in its last cycle only if interrupt enable clears too
module wdt_top
  import wdt_pkg::*;
#(
  parameter logic [21:0] INTV0 = `WDT_INTV0,
  parameter logic [21:0] INTV1 = `WDT_INTV1,
  parameter logic [21:0] INTV2 = `WDT_INTV2,
  parameter logic [21:0] INTV3 = `WDT_INTV3
) (
  // Clock and power-on reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Other resets and brownout pin
  input  wire logic        soft_reset_i,
  input  wire logic        brownout_i,
  // APB
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  // Events
  output logic             irq_o,
  output logic             wdt_reset_o
);

  // ========================================================================
  // Decode helpers
  function automatic logic is_reg(input logic [11:0] a,
                                  input logic [11:0] ofs);
    is_reg = (a == ofs);
  endfunction

  function automatic logic [21:0] intv_of(input logic [1:0] sel);
    case (sel)
      2'h0:    intv_of = INTV0;
      2'h1:    intv_of = INTV1;
      2'h2:    intv_of = INTV2;
      default: intv_of = INTV3;
    endcase
  endfunction

  // ========================================================================
  // Signals
  wdt_state_t   q;
  wdt_state_t   s;
  wdt_apb_req_t req;
  wdt_apb_rsp_t rsp;
  logic         brown_s;
  logic         wr;
  logic         wctl;
  logic         wsts;
  logic         wmsk;
  logic [7:0]   wdat;
  logic         hit;
  logic [31:0]  rdata;
  logic         elapse;
  logic         halted;

  // ========================================================================
  // Brownout pin synchroniser
  wdt_sync2 u_brown (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (brownout_i),
    .q_o      (brown_s)
  );

  // ========================================================================
  // Bus slave
  always_comb begin
    req.psel    = psel_i;
    req.penable = penable_i;
    req.pwrite  = pwrite_i;
    req.paddr   = paddr_i;
    req.pwdata  = pwdata_i;
  end

  assign hit = is_reg(paddr_i, `WDT_CTRL_OFS) |
               is_reg(paddr_i, `WDT_STS_OFS) |
               is_reg(paddr_i, `WDT_MSK_OFS);

  always_comb begin
    rdata = 32'h0;
    if (is_reg(paddr_i, `WDT_CTRL_OFS)) begin
      rdata[`WDT_B_POR]    = q.por;
      rdata[`WDT_B_IRQEN]  = q.irq_en;
      rdata[`WDT_B_SEL_HI] = q.sel[1];
      rdata[`WDT_B_SEL_LO] = q.sel[0];
      rdata[`WDT_B_FLAG]   = q.flag;
      rdata[`WDT_B_RSTEN]  = q.rst_en;
      rdata[`WDT_B_RESTART] = 1'b0;
    end else if (is_reg(paddr_i, `WDT_STS_OFS)) begin
      rdata[1:0] = q.sts;
    end else if (is_reg(paddr_i, `WDT_MSK_OFS)) begin
      rdata[1:0] = q.msk;
    end
  end

  wdt_apb_slv u_apb (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .req_i     (req),
    .rsp_o     (rsp),
    .rd_data_i (rdata),
    .rd_hit_i  (hit),
    .wr_o      (wr)
  );

  assign wctl = wr & is_reg(paddr_i, `WDT_CTRL_OFS);
  assign wsts = wr & is_reg(paddr_i, `WDT_STS_OFS);
  assign wmsk = wr & is_reg(paddr_i, `WDT_MSK_OFS);
  assign wdat = pwdata_i[7:0];

  // ========================================================================
  // Watchdog core
  assign halted = ~q.irq_en & ~q.rst_en;
  assign elapse = (q.st != WDT_HALT) &&
                  (q.cnt == intv_of(q.sel) - 22'h1);

  always_comb begin
    s       = q;
    s.wdrst = 1'b0;
    // Counting phases
    case (q.st)
      WDT_HALT: begin
        s.cnt = q.cnt;
      end
      WDT_COUNT: begin
        s.cnt = q.cnt + 22'h1;
        if (elapse) begin
          s.cnt = 22'h0;
          if (q.rst_en) begin
            s.st   = WDT_RWAIT;
            s.rcnt = 9'h0;
          end
        end
      end
      WDT_RWAIT: begin
        s.cnt  = elapse ? 22'h0 : q.cnt + 22'h1;
        s.rcnt = q.rcnt + 9'h1;
        if (q.rcnt == `WDT_RST_LAST) begin
          s.wdrst = 1'b1;
          s.st    = WDT_COUNT;
        end
      end
      default: begin
        s.st = WDT_HALT;
      end
    endcase
    // Hardware sets flag
    s.flag = q.flag | elapse;
    // Control writes
    if (wctl) begin
      s.flag   = wdat[`WDT_B_FLAG] | elapse;
      s.irq_en = wdat[`WDT_B_IRQEN];
      s.rst_en = wdat[`WDT_B_RSTEN];
      if (!wdat[`WDT_B_POR]) begin
        s.por = 1'b0;
      end
      s.sel = {wdat[`WDT_B_SEL_HI], wdat[`WDT_B_SEL_LO]};
      if (s.sel != q.sel && q.st != WDT_RWAIT) begin
        s.cnt = 22'h0;
      end
      if (wdat[`WDT_B_RESTART]) begin
        s.cnt  = 22'h0;
        s.rcnt = 9'h0;
        if (q.st == WDT_RWAIT) begin
          s.st = WDT_COUNT;
        end
      end
      if (halted && (s.irq_en || s.rst_en)) begin
        s.cnt  = 22'h0;
        s.rcnt = 9'h0;
        s.st   = WDT_COUNT;
      end
      if (!s.rst_en && s.st == WDT_RWAIT) begin
        s.st    = WDT_COUNT;
        s.wdrst = 1'b0;
      end
      if (!s.irq_en && !s.rst_en) begin
        s.st    = WDT_HALT;
        s.wdrst = 1'b0;
      end
    end
    // Event status, set wins over clear
    if (wsts) begin
      s.sts = q.sts & ~wdat[1:0];
    end
    s.sts[`WDT_B_EV_INTV] = s.sts[`WDT_B_EV_INTV] | elapse;
    s.sts[`WDT_B_EV_RST]  = s.sts[`WDT_B_EV_RST] | s.wdrst;
    if (wmsk) begin
      s.msk = wdat[1:0];
    end
    // Other resets keep enables and power flag
    if (soft_reset_i) begin
      s.st    = (q.irq_en || q.rst_en) ? WDT_COUNT : WDT_HALT;
      s.cnt   = 22'h0;
      s.rcnt  = 9'h0;
      s.sel   = `WDT_SEL_RST;
      s.flag  = 1'b0;
      s.wdrst = 1'b0;
      s.irq_en = q.irq_en;
      s.rst_en = q.rst_en;
      s.por    = q.por;
    end
    // Brownout acts as power-on
    if (brown_s) begin
      s     = '0;
      s.st  = WDT_HALT;
      s.por = 1'b1;
    end
    s.irq = (s.flag & s.irq_en) | (|(s.sts & s.msk));
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      q     <= '0;
      q.st  <= WDT_HALT;
      q.sel <= `WDT_SEL_RST;
      q.sts <= `WDT_EVT_RST;
      q.por <= 1'b1;
    end else begin
      q <= s;
    end
  end

  // ========================================================================
  // Outputs
  assign pready_o    = rsp.pready;
  assign pslverr_o   = rsp.pslverr;
  assign prdata_o    = rsp.prdata;
  assign irq_o       = q.irq;
  assign wdt_reset_o = q.wdrst;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  intv_elapse_a: assert property (
    (q.st != WDT_HALT && q.cnt == intv_of(q.sel) - 22'h1 &&
     !soft_reset_i && !brown_s) |=> q.flag)
    else $error("interval end did not set flag");

  rst_delay_a: assert property (
    (q.st == WDT_RWAIT && q.rcnt == `WDT_RST_LAST && !wctl &&
     !soft_reset_i && !brown_s) |=> q.wdrst)
    else $error("watchdog reset not issued");

  rst_cause_a: assert property (
    q.wdrst |-> $past(q.st) == WDT_RWAIT && $past(q.rst_en))
    else $error("reset without pending countdown");

  irq_on_flag_a: assert property (
    (q.flag && q.irq_en && !wctl && !soft_reset_i && !brown_s)
      |=> irq_o)
    else $error("enabled flag gave no interrupt");

  irq_masked_a: assert property (
    (!q.irq_en && q.msk == 2'h0 && !wctl && !wmsk) |=> !irq_o)
    else $error("interrupt while disabled");

  halt_hold_a: assert property (
    (q.st == WDT_HALT && !wctl && !soft_reset_i && !brown_s)
      |=> $stable(q.cnt) && q.st == WDT_HALT)
    else $error("halted counter moved");

  halt_start_a: assert property (
    (q.st == WDT_HALT && wctl && wdat[`WDT_B_IRQEN] &&
     !soft_reset_i && !brown_s)
      |=> q.cnt == 22'h0 && q.rcnt == 9'h0 ##1 q.cnt == 22'h1)
    else $error("enable from halt did not restart");

  soft_keep_a: assert property (
    (soft_reset_i && !brown_s)
      |=> q.irq_en == $past(q.irq_en) && q.por == $past(q.por))
    else $error("soft reset changed enable or power flag");

  brown_por_a: assert property (
    brown_s |=> q.por && !q.irq_en && q.st == WDT_HALT)
    else $error("brownout did not act as power-on");

  restart_clr_a: assert property (
    (wctl && wdat[`WDT_B_RESTART] && !soft_reset_i && !brown_s)
      |=> q.cnt == 22'h0)
    else $error("restart did not clear count");

  sel_pending_a: assert property (
    (wctl && q.st == WDT_RWAIT && wdat[`WDT_B_RSTEN] &&
     !wdat[`WDT_B_RESTART] && q.rcnt != `WDT_RST_LAST &&
     !soft_reset_i && !brown_s)
      |=> q.st == WDT_RWAIT && q.rcnt == $past(q.rcnt) + 9'h1)
    else $error("select write disturbed pending reset");

  por_clear_a: assert property (
    (wctl && !wdat[`WDT_B_POR] && !brown_s) |=> !q.por)
    else $error("power flag not cleared");

endmodule

`default_nettype wire

// ==== test_watchdog_interval_and_reset_flags.sv ====
`include "wdt_cfg.svh"
`default_nettype none

module test_watchdog_interval_and_reset_flags;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] CT = `WDT_CTRL_OFS;
  localparam logic [11:0] ST = `WDT_STS_OFS;
  localparam logic [11:0] MK = `WDT_MSK_OFS;

  logic        clk_i;
  logic        resetn_i;
  logic        soft_reset_i;
  logic        brownout_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic        wdt_reset_o;
  logic [31:0] rdat;
  logic [31:0] seed;
  logic        rerr;
  logic        seen;
  int          miscompares;
  int          cmp_count;
  int          n;

  // ==========================================================
  // Design
  wdt_top #(
    .INTV0(22'h000010),
    .INTV1(22'h000020),
    .INTV2(22'h000040),
    .INTV3(22'h000080)
  ) dut_u (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .soft_reset_i(soft_reset_i),
    .brownout_i  (brownout_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .pwdata_i    (pwdata_i),
    .pready_o    (pready_o),
    .pslverr_o   (pslverr_o),
    .prdata_o    (prdata_o),
    .irq_o       (irq_o),
    .wdt_reset_o (wdt_reset_o)
  );

  // ==========================================================
  // Helpers
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Shortened interval for a select code
  function automatic int intv(input int sel);
    return 16 << sel;
  endfunction

  // One when v lies in lo to lo plus 2
  function automatic logic [31:0] win(input int v, input int lo);
    return 32'(v >= lo && v <= lo + 2);
  endfunction

  task automatic ticks(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) check("pready", 32'h0, 32'h1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rdat, exp);
  endtask

  // Edges until irq (or reset pulse) is seen, capped at lim
  task automatic meas(input logic rst, input int lim);
    n = 0;
    seen = 1'b0;
    do begin
      @(posedge clk_i);
      n++;
      seen = seen | irq_o;
    end while ((rst ? wdt_reset_o : irq_o) !== 1'b1 && n < lim);
  endtask

  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #500000;
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0] s;
    resetn_i = 1'b0;
    soft_reset_i = 1'b0;
    brownout_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    seed = 32'h1d;
    miscompares = 0;
    cmp_count = 0;
    ticks(12);
    resetn_i <= 1'b1;
    rd(CT, 32'h80, "ctrl");
    rd(ST, 32'h0, "status");
    rd(MK, 32'h0, "mask");
    apb(1'b0, 12'h00c, 32'h0);
    check("slverr", 32'(rerr), 32'h1);
    check("bad rdata", rdat, 32'h0);
    wr(CT, 32'h01);
    rd(CT, 32'h00, "ctrl");
    wr(CT, 32'h80);
    rd(CT, 32'h00, "ctrl");
    for (int i = 0; i < 4; i++) begin
      wr(CT, 32'h40 | 32'(i << 4));
      meas(1'b0, 300);
      check("irq delay", win(n, intv(i)), 32'h1);
      rd(CT, 32'h48 | 32'(i << 4), "ctrl");
      wr(CT, 32'h0);
    end
    wr(CT, 32'h30);
    ticks(300);
    rd(CT, 32'h30, "halted ctrl");
    for (int i = 0; i < 4; i++) begin
      s = (xs() % 2) << 4;
      wr(CT, 32'h40 | s);
      ticks(int'(xs() % 8));
      wr(CT, 32'h41 | s);
      meas(1'b0, 300);
      check("restart delay", win(n, intv(int'(s[4]))), 32'h1);
      wr(CT, 32'h0);
    end
    wr(CT, 32'h08);
    ticks(3);
    check("irq off", 32'(irq_o), 32'h0);
    rd(CT, 32'h08, "ctrl");
    wr(CT, 32'h48);
    meas(1'b0, 4);
    check("irq sw", 32'(n < 4), 32'h1);
    wr(CT, 32'h0);
    wr(CT, 32'h02);
    meas(1'b1, 700);
    check("reset delay", 32'(n >= 528 && n <= 530), 32'h1);
    check("irq masked", 32'(seen), 32'h0);
    wr(CT, 32'h0);
    rd(ST, 32'h3, "status");
    wr(MK, 32'h1);
    ticks(2);
    check("irq mask", 32'(irq_o), 32'h1);
    wr(ST, 32'h3);
    rd(ST, 32'h0, "status");
    check("irq clr", 32'(irq_o), 32'h0);
    wr(MK, 32'h0);
    wr(CT, 32'h02);
    ticks(20);
    wr(CT, 32'h22);
    meas(1'b1, 700);
    check("sel in countdown", 32'(n >= 502 && n <= 507), 32'h1);
    wr(CT, 32'h0);
    wr(CT, 32'h42);
    ticks(20);
    wr(CT, 32'h40);
    meas(1'b1, 600);
    check("reset cancel", 32'(n == 600), 32'h1);
    check("irq kept", 32'(seen), 32'h1);
    wr(CT, 32'h0);
    wr(CT, 32'h02);
    ticks(20);
    wr(CT, 32'h03);
    meas(1'b1, 700);
    check("restart in countdown", win(n, 528), 32'h1);
    wr(CT, 32'h0);
    wr(CT, 32'h70);
    ticks(1);
    soft_reset_i <= 1'b1;
    ticks(1);
    soft_reset_i <= 1'b0;
    rd(CT, 32'h40, "soft ctrl");
    brownout_i <= 1'b1;
    ticks(4);
    brownout_i <= 1'b0;
    ticks(6);
    rd(CT, 32'h80, "bo ctrl");
    wr(CT, 32'h0);
    rd(CT, 32'h0, "ctrl");
    final_report();
  end
endmodule

`default_nettype wire
